// >>> logic/adcc_ctrl.sv
// adcc_ctrl: per-channel trigger, mode, early-interrupt and ready logic of a 22-input adc
// assumes an apb master on CLK, conversion cores reporting done/early pulses with results
//
// Summary of operation
// RQ1 - per input bit: level or edge trigger
// RQ2 - high registers: low six bits, rest zero
// RQ3 - early irq raised only when enabled
// RQ4 - early status set, cleared by buffer read
// RQ5 - odd mode bits select differential input
// RQ6 - even mode bits select signed result
// RQ7 - three mode registers, top bits read zero
// RQ8 - irq enable gates common and individual
// RQ9 - read-only ready flag per channel
// RQ10 - six trigger-select registers, two fields each
// RQ11 - all implemented bits reset to zero
// RQ12 - source 0 none, 1 common, 2 level
// RQ13 - buffer read clears ready, conversion sets
// RQ14 - edge: one conversion; level: repeat while high
module adcc_ctrl
#(
   parameter int unsigned CHANNELS = 22
) (
   // clock and reset
   input  wire logic                  CLK,
   input  wire logic                  NRST,
   // apb slave
   input  wire logic                  PSEL,
   input  wire logic                  PENABLE,
   input  wire logic                  PWRITE,
   input  wire logic [7:0]            PADDR,
   input  wire logic [31:0]           PWDATA,
   output logic      [31:0]           PRDATA,
   output logic                       PREADY,
   output logic                       PSLVERR,
   // trigger sources, index = source code
   input  wire logic [31:0]           TRIG_SRC_IN,
   // conversion cores
   input  wire adcc_pkg::adcc_core_evt_t CORE_EVT,
   input  wire logic [4:0]            CORE_CH,
   input  wire logic [15:0]           CORE_RESULT,
   output logic      [21:0]           CONV_START,
   output logic      [21:0]           DIFFERENTIAL_SEL_MODE,
   output logic      [21:0]           SIGNED_MODE,
   // interrupts
   output logic      [21:0]           CH_IRQ,
   output logic                       COMMON_IRQ,
   output logic                       IRQ
);
   import adcc_pkg::*;

   initial
   begin
      if (CHANNELS != NUM_CH) $error("only 22 channels supported");
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [21:0] level_trigger_sel_reg;
   logic [21:0] early_irq_en_reg;
   logic [21:0] early_irq_flag_reg;
   logic [21:0] differential_sel_reg;
   logic [21:0] sign_sel_reg;
   logic [21:0] channel_irq_en_reg;
   logic [21:0] result_ready_flag_reg;
   logic [11:0] trigger_source_field_reg [NUM_TRGL];
   logic [IRQ_W-1:0] irq_status_reg;
   logic [IRQ_W-1:0] irq_mask_reg;

   adcc_apb_req_t req;
   logic          wr_en;
   logic          rd_en;
   logic          buf_rd;
   logic [4:0]    buf_ch;
   logic [21:0]   buf_rd_mask;
   logic [15:0]   buf_rdata;
   logic          buf_rd_d_reg;
   logic [31:0]   rdata_next;
   logic          addr_ok;

   assign req = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE, paddr: PADDR, pwdata: PWDATA};
   assign wr_en  = req.psel && req.penable && req.pwrite && PREADY;
   assign rd_en  = req.psel && !req.penable && !req.pwrite;
   assign buf_ch = 5'((req.paddr - OFS_BUF0) >> 2);
   assign buf_rd = rd_en && (req.paddr >= OFS_BUF0) && (buf_ch < 5'(NUM_CH))
                   && (req.paddr[1:0] == 2'b00);
   assign buf_rd_mask = buf_rd ? (22'h000001 << buf_ch) : CH_RESET;

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [15:0] pair_pack(input logic [7:0] d, input logic [7:0] s);
      logic [15:0] r;
      r = 16'h0000;
      for (int i = 0; i < 8; i++)
      begin
         r[2*i]   = s[i];
         r[2*i+1] = d[i];
      end
      return r;
   endfunction : pair_pack

   function automatic logic [21:0] merge(input logic [21:0] old, input logic [15:0] d,
                                         input logic hi);
      logic [21:0] r;
      r = old;
      if (hi)
         r[21:16] = d[5:0];
      else
         r[15:0] = d;
      return r;
   endfunction : merge

   ////////////////////////////////////////////////////////////////////////////
   // apb write side
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         level_trigger_sel_reg <= CH_RESET; // RQ11
         early_irq_en_reg      <= CH_RESET;
         channel_irq_en_reg    <= CH_RESET;
         differential_sel_reg  <= CH_RESET;
         sign_sel_reg          <= CH_RESET;
         irq_mask_reg          <= '0;
         for (int i = 0; i < NUM_TRGL; i++)
            trigger_source_field_reg[i] <= 12'h000;
      end
      else if (wr_en)
      begin
         case (req.paddr)
            OFS_LVL_L: level_trigger_sel_reg <= merge(level_trigger_sel_reg, req.pwdata[15:0], 1'b0); // RQ1
            OFS_LVL_H: level_trigger_sel_reg <= merge(level_trigger_sel_reg, req.pwdata[15:0], 1'b1); // RQ2
            OFS_EIE_L: early_irq_en_reg <= merge(early_irq_en_reg, req.pwdata[15:0], 1'b0); // RQ3
            OFS_EIE_H: early_irq_en_reg <= merge(early_irq_en_reg, req.pwdata[15:0], 1'b1); // RQ2
            OFS_IE_L:  channel_irq_en_reg <= merge(channel_irq_en_reg, req.pwdata[15:0], 1'b0); // RQ8
            OFS_IE_H:  channel_irq_en_reg <= merge(channel_irq_en_reg, req.pwdata[15:0], 1'b1); // RQ2
            OFS_MOD_0:
            begin
               for (int i = 0; i < 8; i++)
               begin
                  sign_sel_reg[i]         <= req.pwdata[2*i];   // RQ6
                  differential_sel_reg[i] <= req.pwdata[2*i+1]; // RQ5
               end
            end
            OFS_MOD_1:
            begin
               for (int i = 0; i < 8; i++)
               begin
                  sign_sel_reg[8+i]         <= req.pwdata[2*i];
                  differential_sel_reg[8+i] <= req.pwdata[2*i+1];
               end
            end
            OFS_MOD_2:
            begin
               for (int i = 0; i < 6; i++)
               begin
                  sign_sel_reg[16+i]         <= req.pwdata[2*i]; // RQ7
                  differential_sel_reg[16+i] <= req.pwdata[2*i+1];
               end
            end
            OFS_IRQ_MSK: irq_mask_reg <= req.pwdata[IRQ_W-1:0];
            default:
            begin
               for (int i = 0; i < NUM_TRGL; i++)
                  if (req.paddr == OFS_TRG_L0 + 8'(4*i))
                  begin
                     trigger_source_field_reg[i] <= {req.pwdata[12:8], 2'b00,
                                                     req.pwdata[4:0]}; // RQ10
                  end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // trigger decode and conversion sequencing
   logic [4:0]  src_of   [NUM_CH];
   logic [21:0] trig_lvl;
   logic [21:0] trig_prev_reg;
   logic [21:0] busy_reg;
   logic        sw_common_reg;

   always_comb
   begin
      for (int c = 0; c < NUM_CH; c++)
      begin
         if (c < 4 * NUM_TRGL && (c % 4) < 2)
            src_of[c] = (c % 4 == 0) ? trigger_source_field_reg[c/4][4:0]
                                     : trigger_source_field_reg[c/4][11:7];
         else
            src_of[c] = SRC_NONE;
      end
   end

   always_comb
   begin
      for (int c = 0; c < NUM_CH; c++)
      begin
         case (src_of[c])
            SRC_NONE:  trig_lvl[c] = 1'b0;          // RQ12
            SRC_SWCOM: trig_lvl[c] = sw_common_reg; // RQ12
            SRC_SWLVL: trig_lvl[c] = TRIG_SRC_IN[SRC_SWLVL]; // RQ12
            SRC_RSVD:  trig_lvl[c] = 1'b0;
            default:   trig_lvl[c] = TRIG_SRC_IN[src_of[c]];
         endcase
      end
   end

   // software common trigger: write of a one to the irq status word's bit 31
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         sw_common_reg <= 1'b0;
      else
         sw_common_reg <= wr_en && req.paddr == OFS_IRQ_ST && req.pwdata[31];
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         trig_prev_reg <= CH_RESET;
         busy_reg      <= CH_RESET;
         CONV_START    <= CH_RESET;
      end
      else
      begin
         trig_prev_reg <= trig_lvl;
         for (int c = 0; c < NUM_CH; c++)
         begin
            if (!busy_reg[c] && (level_trigger_sel_reg[c] ? trig_lvl[c] // RQ14
                                 : (trig_lvl[c] && !trig_prev_reg[c])))  // RQ14
            begin
               CONV_START[c] <= 1'b1;
               busy_reg[c]   <= 1'b1;
            end
            else
            begin
               CONV_START[c] <= 1'b0;
               if (CORE_EVT.done[c])
                  busy_reg[c] <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // result buffer
   adcc_result_mem #(.DEPTH(NUM_CH), .WIDTH(RES_W)) u_mem (
      .clk   (CLK),
      .we    (|CORE_EVT.done),
      .waddr (CORE_CH),
      .wdata (CORE_RESULT),
      .raddr (buf_ch),
      .rdata (buf_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // status flags, set wins over clear
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         result_ready_flag_reg <= CH_RESET;
         early_irq_flag_reg    <= CH_RESET;
      end
      else
      begin
         result_ready_flag_reg <= (result_ready_flag_reg & ~buf_rd_mask) | CORE_EVT.done; // RQ13
         early_irq_flag_reg <= (early_irq_flag_reg & ~buf_rd_mask)
                               | (CORE_EVT.early & early_irq_en_reg); // RQ4
      end
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         irq_status_reg <= '0;
      else
      begin
         for (int b = 0; b < IRQ_W; b++)
         begin
            irq_status_reg[b] <= (irq_status_reg[b]
                                  & !(wr_en && req.paddr == OFS_IRQ_ST && req.pwdata[b]))
                                 | (b == IRQ_EARLY ? |(CORE_EVT.early & early_irq_en_reg) // RQ3
                                    : |(CORE_EVT.done & channel_irq_en_reg));
         end
      end
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         CH_IRQ      <= CH_RESET;
         COMMON_IRQ  <= 1'b0;
         IRQ         <= 1'b0;
         DIFFERENTIAL_SEL_MODE   <= CH_RESET;
         SIGNED_MODE <= CH_RESET;
      end
      else
      begin
         CH_IRQ      <= CORE_EVT.done & channel_irq_en_reg; // RQ8
         COMMON_IRQ  <= |(CORE_EVT.done & channel_irq_en_reg); // RQ8
         IRQ         <= |(irq_status_reg & irq_mask_reg);
         DIFFERENTIAL_SEL_MODE   <= differential_sel_reg; // RQ5
         SIGNED_MODE <= sign_sel_reg;         // RQ6
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb read side, no wait state, one for result buffer reads
   always_comb
   begin
      addr_ok    = 1'b1;
      rdata_next = 32'h00000000;
      case (req.paddr)
         OFS_LVL_L:   rdata_next[15:0] = level_trigger_sel_reg[15:0];
         OFS_LVL_H:   rdata_next[5:0]  = level_trigger_sel_reg[21:16]; // RQ2
         OFS_EIE_L:   rdata_next[15:0] = early_irq_en_reg[15:0];
         OFS_EIE_H:   rdata_next[5:0]  = early_irq_en_reg[21:16];
         OFS_EIS_L:   rdata_next[15:0] = early_irq_flag_reg[15:0];
         OFS_EIS_H:   rdata_next[5:0]  = early_irq_flag_reg[21:16];
         OFS_MOD_0:   rdata_next[15:0] = pair_pack(differential_sel_reg[7:0], sign_sel_reg[7:0]);
         OFS_MOD_1:   rdata_next[15:0] = pair_pack(differential_sel_reg[15:8], sign_sel_reg[15:8]);
         OFS_MOD_2:   rdata_next[15:0] = pair_pack({2'b00, differential_sel_reg[21:16]},
                                                   {2'b00, sign_sel_reg[21:16]}); // RQ7
         OFS_IE_L:    rdata_next[15:0] = channel_irq_en_reg[15:0];
         OFS_IE_H:    rdata_next[5:0]  = channel_irq_en_reg[21:16];
         OFS_RDY_L:   rdata_next[15:0] = result_ready_flag_reg[15:0]; // RQ9
         OFS_RDY_H:   rdata_next[5:0]  = result_ready_flag_reg[21:16]; // RQ9
         OFS_IRQ_ST:  rdata_next[IRQ_W-1:0] = irq_status_reg;
         OFS_IRQ_MSK: rdata_next[IRQ_W-1:0] = irq_mask_reg;
         default:
         begin
            addr_ok = buf_rd || !rd_en;
            for (int i = 0; i < NUM_TRGL; i++)
               if (req.paddr == OFS_TRG_L0 + 8'(4*i))
               begin
                  rdata_next[4:0]  = trigger_source_field_reg[i][4:0];
                  rdata_next[12:8] = trigger_source_field_reg[i][11:7];
                  addr_ok = 1'b1;
               end
         end
      endcase
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         PREADY       <= 1'b0;
         PRDATA       <= 32'h00000000;
         PSLVERR      <= 1'b0;
         buf_rd_d_reg <= 1'b0;
      end
      else
      begin
         PREADY       <= (req.psel && !req.penable && !buf_rd) || buf_rd_d_reg;
         buf_rd_d_reg <= buf_rd;
         if (buf_rd_d_reg)
            PRDATA <= {16'h0000, buf_rdata};
         else if (req.psel && !req.penable)
         begin
            PRDATA  <= req.pwrite ? 32'h00000000 : rdata_next;
            PSLVERR <= !addr_ok && !req.pwrite;
         end
         else
         begin
            PSLVERR <= 1'b0;
         end
      end
   end
endmodule : adcc_ctrl

// >>> logic/adcc_pkg.sv
// adcc_pkg: register map, field layout and shared types of the adc channel control block
// assumes a 32-bit apb slave, registers one aligned word each
package adcc_pkg;

   localparam int unsigned NUM_CH   = 22;
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned NUM_TRGL = 6;
   localparam int unsigned SRC_W    = 5;

   // register byte offsets
   localparam logic [7:0] OFS_LVL_L   = 8'h00;
   localparam logic [7:0] OFS_LVL_H   = 8'h04;
   localparam logic [7:0] OFS_EIE_L   = 8'h08;
   localparam logic [7:0] OFS_EIE_H   = 8'h0c;
   localparam logic [7:0] OFS_EIS_L   = 8'h10;
   localparam logic [7:0] OFS_EIS_H   = 8'h14;
   localparam logic [7:0] OFS_MOD_0   = 8'h18;
   localparam logic [7:0] OFS_MOD_1   = 8'h1c;
   localparam logic [7:0] OFS_MOD_2   = 8'h20;
   localparam logic [7:0] OFS_IE_L    = 8'h24;
   localparam logic [7:0] OFS_IE_H    = 8'h28;
   localparam logic [7:0] OFS_RDY_L   = 8'h2c;
   localparam logic [7:0] OFS_RDY_H   = 8'h30;
   localparam logic [7:0] OFS_IRQ_ST  = 8'h34;
   localparam logic [7:0] OFS_IRQ_MSK = 8'h38;
   localparam logic [7:0] OFS_TRG_L0  = 8'h40;
   localparam logic [7:0] OFS_BUF0    = 8'h80;

   // field layout
   localparam int unsigned LOW_W      = 16;
   localparam int unsigned HIGH_W     = 6;
   localparam int unsigned MOD2_W     = 12;
   localparam int unsigned SRC_A_LSB  = 0;
   localparam int unsigned SRC_B_LSB  = 8;
   localparam int unsigned IRQ_EARLY  = 0;
   localparam int unsigned IRQ_DONE   = 1;
   localparam int unsigned IRQ_W      = 2;
   localparam int unsigned RES_W      = 16;

   localparam logic [21:0] CH_RESET   = 22'h000000;
   localparam logic [4:0]  SRC_NONE   = 5'h00;
   localparam logic [4:0]  SRC_SWCOM  = 5'h01;
   localparam logic [4:0]  SRC_SWLVL  = 5'h02;
   localparam logic [4:0]  SRC_RSVD   = 5'h03;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } adcc_apb_req_t;

   typedef struct packed {
      logic [21:0] done;
      logic [21:0] early;
   } adcc_core_evt_t;

   typedef enum logic [2:0] {
      CV_IDLE = 3'b001,
      CV_BUSY = 3'b010,
      CV_HOLD = 3'b100
   } adcc_conv_st_t;

endpackage : adcc_pkg

// >>> logic/adcc_result_mem.sv
// adcc_result_mem: per-channel result buffer, registered read port
// assumes one write and one read port in the same clock
module adcc_result_mem #(
   parameter int unsigned DEPTH = 22,
   parameter int unsigned WIDTH = 16
) (
   // clock
   input  wire logic                     clk,
   // write
   input  wire logic                     we,
   input  wire logic [$clog2(DEPTH)-1:0] waddr,
   input  wire logic [WIDTH-1:0]         wdata,
   // read
   input  wire logic [$clog2(DEPTH)-1:0] raddr,
   output logic      [WIDTH-1:0]         rdata
);
   logic [WIDTH-1:0] mem [DEPTH];

   initial
   begin
      if (DEPTH < 2) $error("depth too small");
   end

   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule : adcc_result_mem

// >>> verif/adcc_core_model.sv
// adcc_core_model: behavioural conversion core facing adcc_ctrl
// assumes one conversion at a time, latency lat of at least 3 cycles
module adcc_core_model
(
   // clock and reset
   input wire logic                 clk,
   input wire logic                 nrst,
   // control
   input wire logic [21:0]          conv_start,
   input wire logic [3:0]           lat,
   // results
   output adcc_pkg::adcc_core_evt_t core_evt,
   output logic [4:0]               core_ch,
   output logic [15:0]              core_result
);
   timeunit 1ns;
   timeprecision 1ps;
   import adcc_pkg::*;
   logic       busy;
   logic [3:0] cnt;
   logic [4:0] ch;
   // result lines toggle outside the done cycle
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         busy <= 1'b0;
         cnt <= 4'h0;
         ch <= 5'h00;
         core_evt <= '0;
         core_ch <= 5'h00;
         core_result <= 16'h0000;
      end
      else
      begin
         core_evt <= '0;
         core_ch <= ~core_ch;
         core_result <= ~core_result;
         if (!busy && conv_start != 22'h0)
         begin
            busy <= 1'b1;
            cnt <= lat;
            for (int i = 21; i >= 0; i--)
               if (conv_start[i])
                  ch <= i[4:0];
         end
         else if (busy)
         begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h2)
               core_evt.early[ch] <= 1'b1;
            if (cnt == 4'h1)
            begin
               core_evt.done[ch] <= 1'b1;
               core_ch <= ch;
               core_result <= {11'h2d0, ch};
               busy <= 1'b0;
            end
         end
      end
   end
endmodule : adcc_core_model

// >>> verif/adcc_ctrl_props.sv
// adcc_ctrl_props: port-level assertions for adcc_ctrl
// assumes it is bound to every adcc_ctrl instance
module adcc_ctrl_props
(
   // clock and reset
   input wire logic                    CLK,
   input wire logic                    NRST,
   // apb
   input wire logic                    PSEL,
   input wire logic                    PENABLE,
   input wire logic                    PWRITE,
   input wire logic [7:0]              PADDR,
   input wire logic                    PREADY,
   input wire logic                    PSLVERR,
   // core side and interrupts
   input wire adcc_pkg::adcc_core_evt_t CORE_EVT,
   input wire logic [21:0]             CONV_START,
   input wire logic [21:0]             DIFFERENTIAL_SEL_MODE,
   input wire logic [21:0]             SIGNED_MODE,
   input wire logic [21:0]             CH_IRQ,
   input wire logic                    COMMON_IRQ
);
   timeunit 1ns;
   timeprecision 1ps;
   import adcc_pkg::*;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   logic wr_acc;
   assign wr_acc = PSEL && PENABLE && PWRITE && PREADY;
   logic buf_req;
   assign buf_req = PSEL && !PENABLE && !PWRITE && PADDR >= OFS_BUF0
                    && PADDR < OFS_BUF0 + 8'(4 * NUM_CH) && PADDR[1:0] == 2'b00;
   ////////////////////////////////////////////////////////////////////////////////
   property p_ready_wait;
      PSEL && !PENABLE && !buf_req |=> PREADY;
   endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("no ready after setup");
   property p_buf_wait;
      buf_req |=> !PREADY ##1 PREADY;
   endproperty
   a_buf_wait: assert property (p_buf_wait) else $error("buffer read answer not after two cycles");
   property p_ready_pulse;
      PREADY |=> !PREADY;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
   property p_err_read;
      PSLVERR |-> PREADY && !PWRITE;
   endproperty
   a_err_read: assert property (p_err_read) else $error("error outside a read answer");
   property p_common;
      COMMON_IRQ == (CH_IRQ != 22'h0);
   endproperty
   a_common: assert property (p_common) else $error("common irq not or of channels");
   property p_chirq_cause;
      CH_IRQ != 22'h0 |-> (CH_IRQ & ~$past(CORE_EVT.done)) == 22'h0;
   endproperty
   a_chirq_cause: assert property (p_chirq_cause) else $error("channel irq without done");
   property p_start_pulse;
      CONV_START != 22'h0 |-> (CONV_START & $past(CONV_START)) == 22'h0;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start held two cycles");
   property p_differential_sel_hold;
      !$past(wr_acc) && !$past(wr_acc, 2) |-> $stable(DIFFERENTIAL_SEL_MODE);
   endproperty
   a_differential_sel_hold: assert property (p_differential_sel_hold) else $error("differential_sel mode moved unwritten");
   property p_sign_hold;
      !$past(wr_acc) && !$past(wr_acc, 2) |-> $stable(SIGNED_MODE);
   endproperty
   a_sign_hold: assert property (p_sign_hold) else $error("sign mode moved unwritten");
endmodule : adcc_ctrl_props

bind adcc_ctrl adcc_ctrl_props i_props (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR), .CORE_EVT(CORE_EVT),
   .CONV_START(CONV_START), .DIFFERENTIAL_SEL_MODE(DIFFERENTIAL_SEL_MODE), .SIGNED_MODE(SIGNED_MODE),
   .CH_IRQ(CH_IRQ), .COMMON_IRQ(COMMON_IRQ));

// >>> verif/adcc_ctrl_tb_top.sv
// adcc_ctrl_tb_top: self-checking bench for adcc_ctrl
// assumes adcc_core_model as the conversion core, apb master here
module adcc_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import adcc_pkg::*;
   logic clk, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, common_irq, irq;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, trig = 32'h0, rdat;
   logic rerr;
   logic [3:0] lat = 4'h3;
   logic [21:0] conv_start, differential_sel_mode, signed_mode, ch_irq;
   logic [4:0] core_ch;
   logic [15:0] core_res;
   adcc_core_evt_t evt;
   int err_total = 0, checks_done = 0, n_start = 0, n_irq = 0;
   logic [7:0] ofs_t [15] = '{OFS_LVL_L, OFS_LVL_H, OFS_EIE_L, OFS_EIE_H, OFS_EIS_L,
      OFS_EIS_H, OFS_MOD_0, OFS_MOD_1, OFS_MOD_2, OFS_IE_L, OFS_IE_H, OFS_RDY_L, OFS_RDY_H,
      OFS_TRG_L0, 8'h54};
   logic [31:0] msk_t [15] = '{32'hffff, 32'h3f, 32'hffff, 32'h3f, 32'h0, 32'h0, 32'hffff,
      32'hffff, 32'hfff, 32'hffff, 32'h3f, 32'h0, 32'h0, 32'h1f1f, 32'h1f1f};
   adcc_ctrl i_dut (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .TRIG_SRC_IN(trig), .CORE_EVT(evt), .CORE_CH(core_ch), .CORE_RESULT(core_res),
      .CONV_START(conv_start), .DIFFERENTIAL_SEL_MODE(differential_sel_mode), .SIGNED_MODE(signed_mode),
      .CH_IRQ(ch_irq), .COMMON_IRQ(common_irq), .IRQ(irq));
   adcc_core_model i_core (.clk(clk), .nrst(nrst), .conv_start(conv_start), .lat(lat),
      .core_evt(evt), .core_ch(core_ch), .core_result(core_res));
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (conv_start[0] === 1'b1) n_start++;
      if (ch_irq[0] === 1'b1) n_irq++;
   end
   task final_report;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : final_report
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e)
      begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
      begin
         @(posedge clk);
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask : rd
   ////////////////////////////////////////////////////////////////////////////////
   task t_access;
      for (int i = 0; i < 15; i++)
      begin
         rd(ofs_t[i], 32'h0);
         wr(ofs_t[i], 32'hffffffff);
         rd(ofs_t[i], msk_t[i]);
         wr(ofs_t[i], 32'h0);
      end
      apb(1'b0, 8'hfc, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      rd(OFS_LVL_L, 32'h0);
      chk({31'h0, rerr}, 32'h0);
   endtask : t_access
   task t_mode;
      wr(OFS_MOD_0, 32'haaaa);
      wr(OFS_MOD_1, 32'h5555);
      wr(OFS_MOD_2, 32'haaa);
      repeat (3) @(posedge clk);
      chk(32'(differential_sel_mode), 32'h3f00ff);
      chk(32'(signed_mode), 32'h00ff00);
      rd(OFS_MOD_0, 32'haaaa);
      rd(OFS_MOD_1, 32'h5555);
      rd(OFS_MOD_2, 32'haaa);
      wr(OFS_MOD_0, 32'h0);
      wr(OFS_MOD_1, 32'h0);
      wr(OFS_MOD_2, 32'h0);
   endtask : t_mode
   task t_edge;
      wr(OFS_TRG_L0, {27'h0, SRC_SWLVL});
      wr(OFS_IE_L, 32'h1);
      wr(OFS_IRQ_MSK, 32'h2);
      n_start = 0;
      n_irq = 0;
      trig[2] <= 1'b1;
      repeat (20) @(posedge clk);
      trig[2] <= 1'b0;
      chk(n_start, 32'h1);
      chk(n_irq, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr(OFS_IRQ_ST, 32'h2);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      rd(OFS_RDY_L, 32'h1);
      rd(OFS_BUF0, 32'h5a00);
      rd(OFS_RDY_L, 32'h0);
   endtask : t_edge
   task t_level;
      int k;
      lat <= 4'h9;
      wr(OFS_LVL_L, 32'h1);
      n_start = 0;
      trig[2] <= 1'b1;
      repeat (30) @(posedge clk);
      trig[2] <= 1'b0;
      chk(32'(n_start >= 2), 32'h1);
      repeat (15) @(posedge clk);
      k = n_start;
      repeat (15) @(posedge clk);
      chk(n_start, k);
      rd(OFS_BUF0, 32'h5a00);
      wr(OFS_LVL_L, 32'h0);
      wr(OFS_IRQ_ST, 32'h3);
   endtask : t_level
   task t_src;
      logic [4:0] code [3] = '{SRC_NONE, SRC_SWCOM, SRC_RSVD};
      for (int i = 0; i < 3; i++)
      begin
         wr(OFS_TRG_L0, {27'h0, code[i]});
         n_start = 0;
         trig <= 32'h9;
         wr(OFS_IRQ_ST, 32'h80000000);
         repeat (14) @(posedge clk);
         trig <= 32'h0;
         chk(n_start, 32'(code[i] == SRC_SWCOM));
         apb(1'b0, OFS_BUF0, 32'h0);
         wr(OFS_IRQ_ST, 32'h3);
      end
   endtask : t_src
   task t_early;
      lat <= 4'h6;
      wr(OFS_TRG_L0, {27'h0, SRC_SWCOM});
      wr(OFS_IRQ_MSK, 32'h1);
      for (int en = 1; en >= 0; en--)
      begin
         wr(OFS_EIE_L, 32'(en));
         wr(OFS_IRQ_ST, 32'h80000000);
         repeat (12) @(posedge clk);
         rd(OFS_EIS_L, 32'(en));
         chk({31'h0, irq}, 32'(en));
         rd(OFS_BUF0, 32'h5a00);
         rd(OFS_EIS_L, 32'h0);
         wr(OFS_IRQ_ST, 32'h3);
      end
   endtask : t_early
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      final_report;
   end
   initial
   begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      t_access;
      t_mode;
      t_edge;
      t_level;
      t_src;
      t_early;
      final_report;
   end
endmodule : adcc_ctrl_tb_top
